// [rtl/board_status_pkg.sv]
/*
 * Constants for the read-only board status register bank: byte offsets,
 * bus bit positions of each status field and the reset-cause encoding.
 * Assumes an 8-bit register port with 16-bit byte addresses; bits are
 * numbered here as bus data bits, bit 0 being the least significant.
 */
//
// How it works
// RULE1: Eight-bit read-only slot address register at offset
// RULE2: Live active-low slot pins, parity above address
// RULE3: Site 1 empty reads one, fitted zero
// RULE4: Site 2 empty reads one, fitted zero
// RULE5: Memory board 1 absent flag, active low
// RULE6: Memory board 2 absent flag, active low
// RULE7: Expansion slot absent flag in second features register
// RULE8: Reset cause kept and readable after reset
// RULE9: Power-up flag after power-on or undervoltage reset
// RULE10: Panel button flag after push button reset
// RULE11: Watchdog stage two flag after its expiry
// RULE12: Backplane reset flags reserved, never set here
// RULE13: Software hard reset flag after fast reset
// RULE14: Both feature registers share one offset
// RULE15: Writes ignored, unused bits carry no meaning
// RULE16: New reset clears old flags, sets one
package board_status_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Byte offsets of the bank
    localparam logic [15:0] SLOT_ADDR_OFS = 16'h80e8;
    localparam logic [15:0] FEATURES_OFS = 16'h80f0;
    localparam logic [15:0] RESET_CAUSE_OFS = 16'h80f8;

    // Slot address register: parity above the five address pins
    localparam int SLOT_PARITY_BIT = 5;
    localparam int SLOT_ADDR_LSB = 0;

    // Shared features register fields
    localparam int EXP_SLOT_BIT = 7;
    localparam int SITE1_BIT = 4;
    localparam int SITE2_BIT = 3;
    localparam int MEM1_BIT = 1;
    localparam int MEM2_BIT = 0;

    // Reset cause register fields
    localparam int POWERUP_BIT = 0;
    localparam int PANEL_BIT = 1;
    localparam int WATCHDOG_BIT = 2;
    localparam int BP_LINE_BIT = 3;
    localparam int BP_CMD_BIT = 4;
    localparam int SW_HARD_BIT = 5;

    // Index of each cause in the synchronised cause vector
    localparam int CAUSE_POWERUP = 0;
    localparam int CAUSE_PANEL = 1;
    localparam int CAUSE_WATCHDOG = 2;
    localparam int CAUSE_SW_HARD = 3;
    localparam int NUM_CAUSES = 4;

    // Read data reset value and fill for unused bits
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [7:0] UNUSED_BITS = 8'h00;

endpackage

// [rtl/board_status_regs.sv]
/*
 * Read-only board status bank: slot address pins, mezzanine and expansion
 * presence pins, and a record of the cause of the most recent board reset.
 * Assumes the board reset controller holds each cause level high through
 * the reset it causes and until at least three clocks after srst_in falls.
 */
`timescale 1ns/1ps
`default_nettype none

module board_status_regs
(
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    output logic [7:0] rdata_out,
    input wire logic slot_parity_n_in,
    input wire logic slot_addr4_n_in,
    input wire logic slot_addr3_n_in,
    input wire logic slot_addr2_n_in,
    input wire logic slot_addr1_n_in,
    input wire logic slot_addr0_n_in,
    input wire logic site1_card_absent_in,
    input wire logic site2_card_absent_in,
    input wire logic mem_board1_absent_in,
    input wire logic mem_board2_absent_in,
    input wire logic expansion_slot_absent_in,
    input wire logic powerup_cause_in,
    input wire logic panel_button_cause_in,
    input wire logic watchdog_stage2_cause_in,
    input wire logic software_hard_cause_in
);

    localparam int NPINS = 11;

    logic [NPINS-1:0] pins_raw;
    logic [NPINS-1:0] pins_meta_q;
    logic [NPINS-1:0] pins_q;
    logic [3:0] cause_raw;
    logic [3:0] cause_meta_q;
    logic [3:0] cause_sync_q;
    logic [3:0] cause_prev_q;
    logic [3:0] cause_rise;
    logic [7:0] last_cause_q;
    logic [7:0] last_cause_d;
    logic [7:0] slot_byte;
    logic [7:0] features_byte;
    logic [7:0] read_mux;
    logic [7:0] rdata_q;

    // Pin vector order: 5..0 slot pins, then presence flags
    assign pins_raw = {expansion_slot_absent_in, mem_board2_absent_in,
                       mem_board1_absent_in, site2_card_absent_in,
                       site1_card_absent_in, slot_parity_n_in,
                       slot_addr4_n_in, slot_addr3_n_in, slot_addr2_n_in,
                       slot_addr1_n_in, slot_addr0_n_in};

    assign cause_raw = {software_hard_cause_in, watchdog_stage2_cause_in,
                        panel_button_cause_in, powerup_cause_in};

    // Board pins are asynchronous; two flops before any use
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            pins_meta_q <= '0;
            pins_q <= '0;
        end
        else
        begin
            pins_meta_q <= pins_raw;
            pins_q <= pins_meta_q;
        end
    end

    // Cause levels from the reset controller, same treatment
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            cause_meta_q <= 4'h0;
            cause_sync_q <= 4'h0;
            cause_prev_q <= 4'h0;
        end
        else
        begin
            cause_meta_q <= cause_raw;
            cause_sync_q <= cause_meta_q;
            cause_prev_q <= cause_sync_q;
        end
    end

    // A cause still high after release shows as a rise here
    assign cause_rise = cause_sync_q & ~cause_prev_q;

    // Live pin states, no latching
    always_comb
    begin
        slot_byte = board_status_pkg::UNUSED_BITS;
        slot_byte[board_status_pkg::SLOT_ADDR_LSB +: 5] = pins_q[4:0]; // RULE2
        slot_byte[board_status_pkg::SLOT_PARITY_BIT] = pins_q[5]; // RULE2
    end

    // One byte carries both feature views; their bits never overlap
    always_comb
    begin
        features_byte = board_status_pkg::UNUSED_BITS;
        features_byte[board_status_pkg::SITE1_BIT] = pins_q[6]; // RULE3
        features_byte[board_status_pkg::SITE2_BIT] = pins_q[7]; // RULE4
        features_byte[board_status_pkg::MEM1_BIT] = pins_q[8]; // RULE5
        features_byte[board_status_pkg::MEM2_BIT] = pins_q[9]; // RULE6
        features_byte[board_status_pkg::EXP_SLOT_BIT] = pins_q[10]; // RULE7
    end

    // Highest-priority new cause replaces the whole record
    always_comb
    begin
        last_cause_d = last_cause_q;
        if (cause_rise[board_status_pkg::CAUSE_POWERUP])
        begin
            last_cause_d = 8'h00; // RULE16
            last_cause_d[board_status_pkg::POWERUP_BIT] = 1'b1; // RULE9
        end
        else if (cause_rise[board_status_pkg::CAUSE_PANEL])
        begin
            last_cause_d = 8'h00; // RULE16
            last_cause_d[board_status_pkg::PANEL_BIT] = 1'b1; // RULE10
        end
        else if (cause_rise[board_status_pkg::CAUSE_WATCHDOG])
        begin
            last_cause_d = 8'h00; // RULE16
            last_cause_d[board_status_pkg::WATCHDOG_BIT] = 1'b1; // RULE11
        end
        else if (cause_rise[board_status_pkg::CAUSE_SW_HARD])
        begin
            last_cause_d = 8'h00; // RULE16
            last_cause_d[board_status_pkg::SW_HARD_BIT] = 1'b1; // RULE13
        end
        // Backplane causes do not exist on this board
        last_cause_d[board_status_pkg::BP_LINE_BIT] = 1'b0; // RULE12
        last_cause_d[board_status_pkg::BP_CMD_BIT] = 1'b0; // RULE12
    end

    // Deliberately outside srst_in: the record must outlive the reset
    always_ff @(posedge clock_in)
    begin
        last_cause_q <= last_cause_d; // RULE8
    end

    // Address decode; unmapped offsets read zero
    always_comb
    begin
        case (addr_in)
            board_status_pkg::SLOT_ADDR_OFS: read_mux = slot_byte; // RULE1
            board_status_pkg::FEATURES_OFS: read_mux = features_byte; // RULE14
            board_status_pkg::RESET_CAUSE_OFS: read_mux = last_cause_q; // RULE8
            default: read_mux = board_status_pkg::UNUSED_BITS;
        endcase
    end

    // Read data valid only in the cycle after the strobe; writes dropped
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
            rdata_q <= board_status_pkg::RDATA_RESET;
        else if (rd_strobe_in)
            rdata_q <= read_mux; // RULE15
        else
            rdata_q <= board_status_pkg::RDATA_RESET;
    end

    assign rdata_out = rdata_q;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (srst_in);

    a_slot_read_value: assert property ( // RULE1
        rd_strobe_in && addr_in == board_status_pkg::SLOT_ADDR_OFS
        |=> rdata_out == {2'b00, $past(pins_q[5:0])})
        else $error("slot address read wrong");

    a_slot_pin_path: assert property ( // RULE2
        rd_strobe_in && addr_in == board_status_pkg::SLOT_ADDR_OFS
        ##0 $past(slot_addr0_n_in, 2) ##1 1'b1
        |-> rdata_out[0])
        else $error("slot pin not reaching data");

    a_site1_flag: assert property ( // RULE3
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::SITE1_BIT] == $past(pins_q[6]))
        else $error("site 1 flag wrong");

    a_site2_flag: assert property ( // RULE4
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::SITE2_BIT] == $past(pins_q[7]))
        else $error("site 2 flag wrong");

    a_mem1_flag: assert property ( // RULE5
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::MEM1_BIT] == $past(pins_q[8]))
        else $error("memory board 1 flag wrong");

    a_mem2_flag: assert property ( // RULE6
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::MEM2_BIT] == $past(pins_q[9]))
        else $error("memory board 2 flag wrong");

    a_exp_slot_flag: assert property ( // RULE7
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::EXP_SLOT_BIT] == $past(pins_q[10]))
        else $error("expansion slot flag wrong");

    // Pin to read data: two synchroniser flops plus the read register
    a_parity_pin_path: assert property ( // RULE2
        rd_strobe_in && addr_in == board_status_pkg::SLOT_ADDR_OFS
        |=> rdata_out[board_status_pkg::SLOT_PARITY_BIT] == $past(slot_parity_n_in, 3))
        else $error("slot parity pin not reaching data");

    a_addr4_pin_path: assert property ( // RULE2
        rd_strobe_in && addr_in == board_status_pkg::SLOT_ADDR_OFS
        |=> rdata_out[board_status_pkg::SLOT_ADDR_LSB + 4] == $past(slot_addr4_n_in, 3))
        else $error("slot address 4 pin not reaching data");

    a_site1_pin_path: assert property ( // RULE3
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::SITE1_BIT] == $past(site1_card_absent_in, 3))
        else $error("site 1 pin not reaching data");

    a_site2_pin_path: assert property ( // RULE4
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::SITE2_BIT] == $past(site2_card_absent_in, 3))
        else $error("site 2 pin not reaching data");

    a_mem1_pin_path: assert property ( // RULE5
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::MEM1_BIT] == $past(mem_board1_absent_in, 3))
        else $error("memory board 1 pin not reaching data");

    a_mem2_pin_path: assert property ( // RULE6
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::MEM2_BIT] == $past(mem_board2_absent_in, 3))
        else $error("memory board 2 pin not reaching data");

    a_exp_pin_path: assert property ( // RULE7
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[board_status_pkg::EXP_SLOT_BIT] == $past(expansion_slot_absent_in, 3))
        else $error("expansion slot pin not reaching data");

    // Unmapped offsets must not leak any register
    a_unmapped_zero: assert property ( // RULE15
        rd_strobe_in && addr_in != board_status_pkg::SLOT_ADDR_OFS
        && addr_in != board_status_pkg::FEATURES_OFS
        && addr_in != board_status_pkg::RESET_CAUSE_OFS
        |=> rdata_out == 8'h00)
        else $error("unmapped offset returned data");

    // Watches the record through reset, so reset must not disable it
    a_cause_survives: assert property (@(posedge clock_in) disable iff (1'b0) // RULE8
        (srst_in && last_cause_q != 8'h00) ##1 srst_in |=> $stable(last_cause_q))
        else $error("reset cause lost in reset");

    a_powerup_sets: assert property ( // RULE9
        $rose(cause_sync_q[board_status_pkg::CAUSE_POWERUP]) ##1 1'b1
        |-> last_cause_q == 8'h01)
        else $error("power-up flag not set");

    a_panel_sets: assert property ( // RULE10
        $rose(cause_sync_q[board_status_pkg::CAUSE_PANEL])
        && !cause_rise[board_status_pkg::CAUSE_POWERUP]
        |=> last_cause_q == 8'h02)
        else $error("panel button flag not set");

    a_watchdog_sets: assert property ( // RULE11
        cause_rise == 4'h4 |=> last_cause_q == 8'h04)
        else $error("watchdog flag not set");

    a_backplane_zero: assert property ( // RULE12
        rd_strobe_in && addr_in == board_status_pkg::RESET_CAUSE_OFS
        |=> rdata_out[4:3] == 2'b00)
        else $error("backplane cause bits set");

    a_soft_reset_sets: assert property ( // RULE13
        cause_rise == 4'h8 |=> last_cause_q == 8'h20)
        else $error("software reset flag not set");

    a_shared_offset: assert property ( // RULE14
        rd_strobe_in && addr_in == board_status_pkg::FEATURES_OFS
        |=> rdata_out[6:5] == 2'b00 && rdata_out[2] == 1'b0)
        else $error("features register unused bits set");

    a_write_ignored: assert property ( // RULE15
        wr_strobe_in && cause_rise == 4'h0 |=> $stable(last_cause_q))
        else $error("write changed a register");

    a_single_cause: assert property ( // RULE16
        cause_rise != 4'h0 |=> $onehot(last_cause_q))
        else $error("more than one cause flag set");

    a_idle_data_zero: assert property ( // RULE15
        !rd_strobe_in |=> rdata_out == 8'h00)
        else $error("read data outside its cycle");

endmodule // board_status_regs

`default_nettype wire

// [sim/tb_top.sv]
/*
 * Self-checking bench for the board status register bank: pins, presence
 * flags, reset-cause record, ignored writes and unmapped reads.
 * Assumes the bank answers a read one cycle after the strobe and that each
 * cause level is held through its reset and three clocks beyond.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] wdata_in = 8'h00;
    logic wr_strobe_in = 1'b0;
    logic rd_strobe_in = 1'b0;
    logic [7:0] rdata_out;
    logic [10:0] pins_q = 11'h000;
    logic [3:0] cause_q = 4'h1;
    logic [7:0] cause_exp = 8'h00;
    logic [31:0] lfsr_q = 32'hb8e97d92;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    board_status_regs DUT (.clock_in(clock_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .rdata_out(rdata_out),
        .slot_parity_n_in(pins_q[10]), .slot_addr4_n_in(pins_q[9]), .slot_addr3_n_in(pins_q[8]),
        .slot_addr2_n_in(pins_q[7]), .slot_addr1_n_in(pins_q[6]), .slot_addr0_n_in(pins_q[5]),
        .site1_card_absent_in(pins_q[4]), .site2_card_absent_in(pins_q[3]),
        .mem_board1_absent_in(pins_q[2]), .mem_board2_absent_in(pins_q[1]),
        .expansion_slot_absent_in(pins_q[0]), .powerup_cause_in(cause_q[0]),
        .panel_button_cause_in(cause_q[1]), .watchdog_stage2_cause_in(cause_q[2]),
        .software_hard_cause_in(cause_q[3]));

    // Free-running 25 MHz clock
    initial
    begin
        forever #20 clock_in = ~clock_in;
    end

    // Hang guard, well above the roughly 690 cycles the run needs
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Expected byte for any address, from the pins and the last cause
    function automatic logic [7:0] exp_read(input logic [15:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == board_status_pkg::SLOT_ADDR_OFS)
        begin
            v[board_status_pkg::SLOT_PARITY_BIT] = pins_q[10];
            v[board_status_pkg::SLOT_ADDR_LSB +: 5] = pins_q[9:5];
        end
        else if (a == board_status_pkg::FEATURES_OFS)
        begin
            v[board_status_pkg::EXP_SLOT_BIT] = pins_q[0];
            v[board_status_pkg::SITE1_BIT] = pins_q[4];
            v[board_status_pkg::SITE2_BIT] = pins_q[3];
            v[board_status_pkg::MEM1_BIT] = pins_q[2];
            v[board_status_pkg::MEM2_BIT] = pins_q[1];
        end
        else if (a == board_status_pkg::RESET_CAUSE_OFS)
            v = cause_exp;
        return v;
    endfunction

    function automatic logic [7:0] cause_mask(input int i);
        case (i)
            0: return 8'h01 << board_status_pkg::POWERUP_BIT;
            1: return 8'h01 << board_status_pkg::PANEL_BIT;
            2: return 8'h01 << board_status_pkg::WATCHDOG_BIT;
            default: return 8'h01 << board_status_pkg::SW_HARD_BIT;
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked = checked + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One read cycle; the answer is looked at mid-cycle after the strobe
    task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock_in);
        rd_strobe_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_strobe_in <= 1'b0;
        @(negedge clock_in);
        d = rdata_out;
    endtask

    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr_strobe_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_strobe_in <= 1'b0;
    endtask

    // A cause held through a board reset and past the synchroniser
    task automatic fire_reset(input logic [3:0] causes);
        @(posedge clock_in);
        cause_q <= causes;
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        cause_q <= 4'h0;
        repeat (3) @(posedge clock_in);
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence: power-up record, random pins and writes, each cause
    initial
    begin
        logic [7:0] d;
        logic [15:0] a;
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        check(rdata_out, 8'h00);
        repeat (13) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        cause_q <= 4'h0;
        cause_exp = cause_mask(0);
        bus_read(board_status_pkg::RESET_CAUSE_OFS, d);
        check(d, cause_exp);
        @(negedge clock_in);
        check(rdata_out, 8'h00);
        for (int n = 0; n < 40; n++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            @(posedge clock_in);
            pins_q <= (n == 0) ? 11'h7ff : (n == 1) ? 11'h000 : lfsr_q[10:0];
            repeat (3) @(posedge clock_in);
            bus_write(board_status_pkg::SLOT_ADDR_OFS, lfsr_q[31:24]);
            bus_write(board_status_pkg::FEATURES_OFS, lfsr_q[23:16]);
            bus_read(board_status_pkg::SLOT_ADDR_OFS, d);
            check(d, exp_read(board_status_pkg::SLOT_ADDR_OFS));
            bus_read(board_status_pkg::FEATURES_OFS, d);
            check(d, exp_read(board_status_pkg::FEATURES_OFS));
            a = (n < 4) ? 16'h80e8 + 16'(n * 4 + 4) : lfsr_q[27:12];
            bus_read(a, d);
            check(d, exp_read(a));
        end
        // Each cause alone, then a tie where the panel button must win
        for (int i = 1; i < 5; i++)
        begin
            fire_reset(4'h1 << (i % 4));
            cause_exp = cause_mask(i % 4);
            bus_write(board_status_pkg::RESET_CAUSE_OFS, 8'hff);
            bus_read(board_status_pkg::RESET_CAUSE_OFS, d);
            check(d, cause_exp);
        end
        fire_reset(4'h6);
        cause_exp = cause_mask(1);
        bus_read(board_status_pkg::RESET_CAUSE_OFS, d);
        check(d, cause_exp);
        fire_reset(4'h0);
        bus_read(board_status_pkg::RESET_CAUSE_OFS, d);
        check(d, cause_exp);
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
